/* File: pkg/wwrg_pkg.sv */
// wwrg_pkg: constants for the window watchdog and reset generator
// assumes a 200 MHz core_clk standing in for the oscillator clock
package wwrg_pkg;
  localparam int unsigned OSC_PER_TICK     = 100;  // oscillator periods per cycle_tick
  localparam int unsigned POWERUP_TICKS    = 64;   // reset hold after supply recovery
  localparam int unsigned CLOSED_TICKS     = 32;   // closed_window_time
  localparam int unsigned OPEN_TICKS       = 32;   // open_window_time
  localparam int unsigned FAULT_TICKS      = 64;   // reset start after closed window start
  localparam int unsigned WD_RESET_TICKS   = 64;   // watchdog reset duration
  localparam int unsigned CLK_PERIOD_PS    = 5000; // core_clk period
  localparam int unsigned FILTER_TIME_NS   = 100;  // reaction_filter_time, plain default
  localparam int unsigned FILTER_CYCLES    =
    (FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [6:0]  DIV_LAST         = 7'h63; // OSC_PER_TICK - 1
  localparam logic [6:0]  TICK_ZERO        = 7'h00;
  localparam logic [7:0]  FILT_ZERO        = 8'h00;
  localparam logic [7:0]  FILT_LAST        = 8'(FILTER_CYCLES);

  typedef enum logic [4:0] {
    WWRG_ST_POR     = 5'h01, // reset low, power-up delay running
    WWRG_ST_CLOSED  = 5'h02, // closed window
    WWRG_ST_OPEN    = 5'h04, // open window
    WWRG_ST_WAITRST = 5'h08, // fault seen, waiting for reset start
    WWRG_ST_WDRST   = 5'h10  // watchdog reset low
  } wwrg_state_type;
endpackage

/* File: rtl/wwrg_top.sv */
// wwrg_top: window watchdog, power-on reset generator and system enable
// assumes supply_low_in and trigger_input come from outside core_clk's domain
//
// Function
// - one cycle_tick equals one hundred oscillator clock periods
// - after supply recovers hold reset_output low 64 ticks, then release high
// - supply dips shorter than reaction_filter_time are ignored; longer ones reset
// - every reset_output rise starts a 32 tick closed window
// - a trigger decoded inside the closed window is a pretrigger fault
// - open window follows closed one; ends on trigger or after 32 ticks
// - sample trigger each tick; high, high, low, low is a valid trigger
// - valid trigger in open window or power event starts new closed window
// - on fault pull reset low 64 ticks after window start, hold 64 ticks
// - trigger whose last low sample lands in open window is correct
// - with reset high, first correct trigger raises system enable
// - system enable drops at once on pretrigger, missing trigger, power-down
`timescale 1ns/1ps
module wwrg_top
  import wwrg_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic supply_low_in,
  input  wire logic trigger_input,
  output logic      reset_output_o,
  output logic      reset_output_oe,
  output logic      system_enable_output_o,
  output logic      system_enable_output_oe
);

  // three-stage synchronisers; stage 1 is read only by stage 2
  logic [2:0] sup_sync_reg, sup_sync_next;
  logic [2:0] trg_sync_reg, trg_sync_next;
  logic       sup_low_reg,  sup_low_next;
  logic       trg_lvl_reg,  trg_lvl_next;

  always_comb begin
    sup_sync_next = {sup_sync_reg[1:0], supply_low_in};
    trg_sync_next = {trg_sync_reg[1:0], trigger_input};
    sup_low_next  = (sup_sync_reg[1] == sup_sync_reg[2]) ? sup_sync_reg[2] : sup_low_reg;
    trg_lvl_next  = (trg_sync_reg[1] == trg_sync_reg[2]) ? trg_sync_reg[2] : trg_lvl_reg;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sup_sync_reg <= 3'h7;
      trg_sync_reg <= 3'h0;
      sup_low_reg  <= 1'b1;
      trg_lvl_reg  <= 1'b0;
    end else begin
      sup_sync_reg <= sup_sync_next;
      trg_sync_reg <= trg_sync_next;
      sup_low_reg  <= sup_low_next;
      trg_lvl_reg  <= trg_lvl_next;
    end
  end

  // tick divider and reaction filter on the supply indication
  logic [6:0] div_reg, div_next;
  logic       tick;
  logic [7:0] filt_reg, filt_next;
  logic       pdown_reg, pdown_next;

  assign tick = (div_reg == DIV_LAST);

  always_comb begin
    div_next   = tick ? TICK_ZERO : div_reg + 7'h01;
    filt_next  = FILT_ZERO;
    pdown_next = pdown_reg;
    if (sup_low_reg) begin
      // a short dip only counts, never acts
      filt_next = (filt_reg == FILT_LAST) ? filt_reg : filt_reg + 8'h01;
      if (filt_reg == FILT_LAST) begin
        pdown_next = 1'b1;
      end
    end else begin
      pdown_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg   <= TICK_ZERO;
      filt_reg  <= FILT_ZERO;
      pdown_reg <= 1'b1;
    end else begin
      div_reg   <= div_next;
      filt_reg  <= filt_next;
      pdown_reg <= pdown_next;
    end
  end

  // trigger sampler: last four tick samples, newest in bit 0
  logic [3:0] samp_reg, samp_next;
  logic       trig_valid;

  always_comb begin
    samp_next = samp_reg;
    if (pdown_reg) begin
      samp_next = 4'h0;
    end else if (tick) begin
      samp_next = {samp_reg[2:0], trg_lvl_reg};
    end
  end

  // high, high, low, low completes on the tick the last low is taken
  assign trig_valid = tick && !pdown_reg && (samp_reg[2:0] == 3'h6) && !trg_lvl_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      samp_reg <= 4'h0;
    end else begin
      samp_reg <= samp_next;
    end
  end

  // window sequencer, reset output and system enable
  wwrg_state_type state_reg, state_next;
  logic [6:0]     cnt_reg, cnt_next;   // ticks in current phase
  logic [6:0]     since_reg, since_next; // ticks since closed window start
  logic           rst_out_reg, rst_out_next;
  logic           sen_reg, sen_next;

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    since_next   = since_reg;
    rst_out_next = rst_out_reg;
    sen_next     = sen_reg;
    if (pdown_reg) begin
      // supply low: everything held, power-up delay rearmed
      state_next   = WWRG_ST_POR;
      cnt_next     = 7'h00;
      since_next   = 7'h00;
      rst_out_next = 1'b0;
      sen_next     = 1'b0;
    end else begin
      if (tick) begin
        cnt_next   = cnt_reg + 7'h01;
        since_next = since_reg + 7'h01;
      end
      case (state_reg)
        WWRG_ST_POR: begin
          if (tick && cnt_reg == 7'(POWERUP_TICKS - 1)) begin
            state_next   = WWRG_ST_CLOSED;
            rst_out_next = 1'b1;
            cnt_next     = 7'h00;
            since_next   = 7'h00;
          end
        end
        WWRG_ST_CLOSED: begin
          if (trig_valid && !(tick && cnt_reg == 7'(CLOSED_TICKS - 1))) begin
            // decoded wholly inside the closed window
            state_next = WWRG_ST_WAITRST;
            sen_next   = 1'b0;
          end else if (trig_valid) begin
            // last sample fell on the window boundary: correct trigger
            state_next = WWRG_ST_CLOSED;
            sen_next   = 1'b1;
            cnt_next   = 7'h00;
            since_next = 7'h00;
          end else if (tick && cnt_reg == 7'(CLOSED_TICKS - 1)) begin
            state_next = WWRG_ST_OPEN;
            cnt_next   = 7'h00;
          end
        end
        WWRG_ST_OPEN: begin
          if (trig_valid) begin
            state_next = WWRG_ST_CLOSED;
            sen_next   = 1'b1;
            cnt_next   = 7'h00;
            since_next = 7'h00;
          end else if (tick && cnt_reg == 7'(OPEN_TICKS - 1)) begin
            // missing trigger: window end coincides with reset start
            state_next   = WWRG_ST_WDRST;
            rst_out_next = 1'b0;
            sen_next     = 1'b0;
            cnt_next     = 7'h00;
          end
        end
        WWRG_ST_WAITRST: begin
          if (tick && since_reg == 7'(FAULT_TICKS - 1)) begin
            state_next   = WWRG_ST_WDRST;
            rst_out_next = 1'b0;
            cnt_next     = 7'h00;
          end
        end
        WWRG_ST_WDRST: begin
          if (tick && cnt_reg == 7'(WD_RESET_TICKS - 1)) begin
            state_next   = WWRG_ST_CLOSED;
            rst_out_next = 1'b1;
            cnt_next     = 7'h00;
            since_next   = 7'h00;
          end
        end
        default: begin
          state_next   = WWRG_ST_POR;
          rst_out_next = 1'b0;
          sen_next     = 1'b0;
          cnt_next     = 7'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= WWRG_ST_POR;
      cnt_reg     <= 7'h00;
      since_reg   <= 7'h00;
      rst_out_reg <= 1'b0;
      sen_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      since_reg   <= since_next;
      rst_out_reg <= rst_out_next;
      sen_reg     <= sen_next;
    end
  end

  // open-drain pins: drive low only, pull-up lives outside
  assign reset_output_o          = 1'b0;
  assign reset_output_oe         = !rst_out_reg;
  assign system_enable_output_o  = 1'b0;
  assign system_enable_output_oe = !sen_reg;

endmodule

/* File: dv/wwrg_monitor.sv */
// wwrg_monitor: pin assertions for the watchdog and reset generator
// assumes it is bound to wwrg_top and sees only its ports, one clock
`timescale 1ns/1ps
module wwrg_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic supply_low_in,
  input wire logic trigger_input,
  input wire logic reset_output_o,
  input wire logic reset_output_oe,
  input wire logic system_enable_output_o,
  input wire logic system_enable_output_oe
);
  logic [13:0] hold_reg, hold_next;
  logic [5:0]  sup_reg, sup_next;
  // saturating counts, so a long hold never wraps into a false pass
  always_comb begin
    hold_next = reset_output_oe ? hold_reg + 14'(hold_reg != 14'h3fff) : 14'h0000;
    sup_next  = supply_low_in ? sup_reg + 6'(sup_reg != 6'h3f) : 6'h00;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg <= 14'h0000;
      sup_reg  <= 6'h00;
    end else begin
      hold_reg <= hold_next;
      sup_reg  <= sup_next;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence en_off;
    system_enable_output_oe [*8];
  endsequence
  pins_low_a: assert property (!reset_output_o && !system_enable_output_o)
    else $error("open drain data not low");
  sup_hold_a: assert property (sup_reg >= 6'h1e |-> reset_output_oe && system_enable_output_oe)
    else $error("supply low but outputs released");
  hold_len_a: assert property ($fell(reset_output_oe) |-> hold_reg >= 14'h189c)
    else $error("reset released too early");
  rst_en_a: assert property (reset_output_oe ##1 reset_output_oe |-> system_enable_output_oe)
    else $error("enable active during reset");
  en_trig_a: assert property ($fell(system_enable_output_oe) |-> !$past(trigger_input, 90))
    else $error("enable without filtered trigger");
  en_rst_a: assert property ($fell(system_enable_output_oe) |-> !reset_output_oe)
    else $error("enable raised while reset low");
  rel_sup_a: assert property ($fell(reset_output_oe) |-> sup_reg == 6'h00)
    else $error("reset released with supply low");
  rel_en_a: assert property ($fell(reset_output_oe) |-> en_off)
    else $error("enable not held off after reset");
endmodule
bind wwrg_top wwrg_monitor u_mon (.core_clk(core_clk), .reset_n(reset_n),
  .supply_low_in(supply_low_in), .trigger_input(trigger_input),
  .reset_output_o(reset_output_o), .reset_output_oe(reset_output_oe),
  .system_enable_output_o(system_enable_output_o),
  .system_enable_output_oe(system_enable_output_oe));

/* File: dv/wwrg_ctrl_model.sv */
// wwrg_ctrl_model: controller that sends one trigger pulse per request
// assumes 100 clocks per tick; the line idles low between pulses
`timescale 1ns/1ps
module wwrg_ctrl_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic fire,
  output logic      trigger_input
);
  logic [9:0] cnt_reg;
  // three ticks high, then low until the next request
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 10'h000;
    end else if (fire) begin
      cnt_reg <= 10'h258;
    end else if (cnt_reg != 10'h000) begin
      cnt_reg <= cnt_reg - 10'h001;
    end
  end
  assign trigger_input = (cnt_reg > 10'h12c);
endmodule

/* File: dv/tb_top.sv */
// tb_top: scenario bench for wwrg_top
// assumes a 200 MHz core_clk and the controller model on the trigger line
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic reset_n, supply_low_in, fire, trigger_input;
  logic rst_oe, en_oe;
  int   mismatches = 0;
  int   num_checks = 0;
  int   cycles = 0;
  int   n;
  always #2.5 core_clk = ~core_clk;
  wwrg_top DUT (.core_clk(core_clk), .reset_n(reset_n), .supply_low_in(supply_low_in),
    .trigger_input(trigger_input), .reset_output_o(), .reset_output_oe(rst_oe),
    .system_enable_output_o(), .system_enable_output_oe(en_oe));
  wwrg_ctrl_model u_ctrl (.core_clk(core_clk), .reset_n(reset_n), .fire(fire),
    .trigger_input(trigger_input));
  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a hang is cut short well past the roughly 54k cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 70000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("[ERR] %0t duration %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t output %b expected %b", $time, got, exp);
    end
  endtask
  // outputs are sampled on the falling edge, inputs change on the rising edge;
  // wait_rst returns on the falling edge where the level was seen
  task automatic wait_rst(input logic lvl, output int cnt);
    cnt = 0;
    while (rst_oe !== lvl && cnt < 8000) begin
      @(negedge core_clk);
      cnt++;
    end
  endtask
  // fire is only ever moved on a rising edge, even with no gap
  task automatic pulse(input int gap);
    @(posedge core_clk);
    repeat (gap) @(posedge core_clk);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (900) @(negedge core_clk);
  endtask
  // the divider free-runs, so the first tick lands anywhere in its period
  task automatic power_up();
    @(posedge core_clk);
    supply_low_in <= 1'b0;
    wait_rst(1'b0, n);
    chk_rng(n, 6300, 6420);
    chk_bit(en_oe, 1'b1);
  endtask
  task automatic good_trigger();
    pulse(3300);
    chk_bit(en_oe, 1'b0);
    chk_bit(rst_oe, 1'b0);
  endtask
  // last low sample lands on the final closed-window tick; a pretrigger
  // verdict would pull enable low again
  task automatic late_trigger();
    pulse(2342);
    chk_bit(en_oe, 1'b0);
    chk_bit(rst_oe, 1'b0);
  endtask
  task automatic pre_trigger();
    pulse(0);
    chk_bit(en_oe, 1'b1);
    wait_rst(1'b1, n);
    chk_rng(n, 4700, 5400);
    wait_rst(1'b0, n);
    chk_rng(n, 6350, 6450);
    chk_bit(en_oe, 1'b1);
  endtask
  // enable is raised first so that its drop on the missed window is visible
  task automatic missing_trigger();
    pulse(3300);
    chk_bit(en_oe, 1'b0);
    wait_rst(1'b1, n);
    chk_rng(n, 5950, 6050);
    chk_bit(en_oe, 1'b1);
    wait_rst(1'b0, n);
    chk_rng(n, 6350, 6450);
  endtask
  // enable is raised first so that the short dip is seen to leave it and the long dip to drop it
  task automatic supply_dip();
    pulse(3300);
    chk_bit(en_oe, 1'b0);
    @(posedge core_clk);
    supply_low_in <= 1'b1;
    repeat (10) @(posedge core_clk);
    supply_low_in <= 1'b0;
    repeat (100) @(negedge core_clk);
    chk_bit(rst_oe, 1'b0);
    chk_bit(en_oe, 1'b0);
    @(posedge core_clk);
    supply_low_in <= 1'b1;
    wait_rst(1'b1, n);
    chk_rng(n, 20, 40);
    chk_bit(en_oe, 1'b1);
    repeat (200) @(posedge core_clk);
    power_up();
  endtask
  initial begin
    reset_n <= 1'b0;
    supply_low_in <= 1'b1;
    fire <= 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    power_up();
    good_trigger();
    late_trigger();
    pre_trigger();
    missing_trigger();
    supply_dip();
    test_done();
  end
endmodule
